//--- hw/fcad_pkg.sv
// fcad_pkg: constants and carrier types for the flash command address decoder
// assumes a single 10 MHz system clock and synchronous active-low reset
package fcad_pkg;
  localparam int FCAD_ADDR_W = 32;
  localparam int FCAD_NBLK = 10;
  // command address byte field
  localparam int FCAD_CMD_HI = 15;
  localparam int FCAD_CMD_LO = 8;
  localparam logic [6:0] FCAD_CMD_54_55 = 7'h2a;
  localparam logic [7:0] FCAD_CMD_AA = 8'haa;
  // data bytes of the sequences
  localparam logic [7:0] FCAD_D_AA = 8'haa;
  localparam logic [7:0] FCAD_D_55 = 8'h55;
  localparam logic [7:0] FCAD_D_F0 = 8'hf0;
  localparam logic [7:0] FCAD_D_90 = 8'h90;
  localparam logic [7:0] FCAD_D_A0 = 8'ha0;
  localparam logic [7:0] FCAD_D_80 = 8'h80;
  localparam logic [7:0] FCAD_D_10 = 8'h10;
  localparam logic [7:0] FCAD_D_30 = 8'h30;
  localparam logic [7:0] FCAD_D_9A = 8'h9a;
  localparam logic [7:0] FCAD_D_6A = 8'h6a;
  // id selector codes
  localparam logic [1:0] FCAD_ID_MFR = 2'b00;
  localparam logic [1:0] FCAD_ID_DEV = 2'b01;
  localparam logic [1:0] FCAD_ID_MAC = 2'b11;
  // lock groups
  localparam logic [1:0] FCAD_GRP_LO = 2'b00;
  localparam logic [1:0] FCAD_GRP_MID = 2'b01;
  localparam logic [1:0] FCAD_GRP_HI = 2'b10;
  // reset values and words per page
  localparam logic FCAD_RDY_RST = 1'b1;
  localparam logic [9:0] FCAD_LOCK_RST = 10'h000;
  localparam int FCAD_PAGE_WORDS = 4;
  // sequence steps, gray along the common prefix
  typedef enum logic [3:0] {
    FCAD_S_IDLE = 4'h0, FCAD_S_C1 = 4'h1, FCAD_S_C2 = 4'h3, FCAD_S_ER3 = 4'h2,
    FCAD_S_ER4 = 4'h6, FCAD_S_ER5 = 4'h7, FCAD_S_ER6 = 4'h5, FCAD_S_IDA = 4'h4,
    FCAD_S_IDRD = 4'hc, FCAD_S_PGM = 4'hd, FCAD_S_RDA = 4'hf
  } fcad_state_type;
  typedef enum logic [1:0] {FCAD_K_BLK = 2'h0, FCAD_K_LPGM = 2'h1, FCAD_K_LERS = 2'h3} fcad_kind_type;
  typedef struct packed {
    logic valid;
    logic write;
    logic [FCAD_ADDR_W-1:0] addr;
    logic [31:0] wdata;
  } fcad_bus_type;
  typedef struct packed {
    logic start;
    logic [1:0] op;
    logic [10:0] page;
    logic [3:0] block;
    logic [31:0] data;
  } fcad_op_type;
  localparam logic [1:0] FCAD_OP_PAGE = 2'd0;
  localparam logic [1:0] FCAD_OP_BLK = 2'd1;
  localparam logic [1:0] FCAD_OP_CHIP = 2'd2;
endpackage

//--- hw/fcad_decoder.sv
// fcad_decoder: command address/data decoder for the on-chip flash macro
// assumes core issues 32-bit writes/reads one per valid cycle; array engine reports done/fail
// Operation
// - command byte sits in address bits 15:8, bits 1:0 zero
// - ordinary command layout accepted in every cycle from the first
// - recommended-zero address bits are ignored, only 1:0 checked, except lock program also needs 19 and 16:11 zero, and bit 10 zero for group 10
// - block erase takes block from bits 19:15 of sixth write
// - erase address maps to one of ten blocks by range
// - page programming takes page from bits 19:9 of fourth write, later words reuse it
// - id read takes selector from bits 15:14 of fourth write
// - selector 00 maker, 01 device, 11 macro code, 10 reserved
// - lock program seventh write: group bits 18:17, bit 10:9
// - group 10 blocks 8-9, group 01 blocks 4-7, group 00 blocks 0-3
// - lock erase clears whole group chosen by bits 18:17
// - sequence addresses with command byte 0x54 or 0x55 recognised
// - ready flag 0 while busy, stays 0 on failure, 1 after reset
// - locked block refuses program and erase
`timescale 1ns/1ps
module fcad_decoder #(
  parameter logic [7:0] MFR_CODE = 8'h11, // arbitrary
  parameter logic [7:0] DEV_CODE = 8'h22, // arbitrary
  parameter logic [7:0] MAC_CODE = 8'h33  // arbitrary
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // core bus
  input fcad_pkg::fcad_bus_type bus_in,
  output logic [31:0] rdata_r,
  output logic id_mode_r,
  // array engine
  output fcad_pkg::fcad_op_type op_r,
  input wire logic op_done,
  input wire logic op_fail,
  // status
  output logic auto_op_ready_flag,
  output logic [9:0] lock_flags_r,
  output logic seq_abort_r
);
  import fcad_pkg::*;

  fcad_state_type state_r, state_nxt;
  fcad_kind_type kind_r;
  logic [7:0] d3_r;
  logic [1:0] id_sel_r;
  logic [1:0] word_cnt_r;
  logic [10:0] program_page_selector;
  logic [10:0] page_sel;
  logic ready_r;
  logic wr, rd, addr_ok, is_54_55, is_aa, hit, fire;
  logic [7:0] wb;
  logic [31:0] a;

  function automatic logic [3:0] blk_of(input logic [19:0] ad);
    if (ad[19:17] != 3'h0) blk_of = 4'd7 - {1'b0, ad[19:17]};
    else if (ad[16]) blk_of = 4'd7;
    else if (ad[15]) blk_of = 4'd9;
    else blk_of = 4'd8;
  endfunction

  function automatic logic [9:0] grp_mask(input logic [1:0] g);
    if (g == FCAD_GRP_HI) grp_mask = 10'h300;
    else if (g == FCAD_GRP_MID) grp_mask = 10'h0f0;
    else if (g == FCAD_GRP_LO) grp_mask = 10'h00f;
    else grp_mask = 10'h000;
  endfunction

  assign a = bus_in.addr;
  assign wb = bus_in.wdata[7:0];
  assign wr = bus_in.valid && bus_in.write;
  assign rd = bus_in.valid && !bus_in.write;
  assign addr_ok = (a[1:0] == 2'b00);
  assign is_54_55 = (a[FCAD_CMD_HI:9] == FCAD_CMD_54_55);
  assign is_aa = (a[FCAD_CMD_HI:FCAD_CMD_LO] == FCAD_CMD_AA);
  assign auto_op_ready_flag = ready_r;
  // the first word brings its own page, later words reuse the latched one
  assign page_sel = (word_cnt_r == 2'd0) ? a[19:9] : program_page_selector;

  // sequence stepping
  always_comb begin
    state_nxt = state_r;
    hit = 1'b0;
    if (wr) begin
      case (state_r)
        FCAD_S_IDLE: hit = addr_ok && is_54_55 && wb == FCAD_D_AA;
        FCAD_S_C1: hit = addr_ok && is_aa && wb == FCAD_D_55;
        FCAD_S_C2: hit = addr_ok && is_54_55 && (wb == FCAD_D_F0 || wb == FCAD_D_90 || wb == FCAD_D_A0 ||
                         wb == FCAD_D_80 || wb == FCAD_D_9A || wb == FCAD_D_6A);
        FCAD_S_ER3: hit = addr_ok && is_54_55 && wb == FCAD_D_AA;
        FCAD_S_ER4: hit = addr_ok && is_aa && wb == FCAD_D_55;
        FCAD_S_ER5: hit = addr_ok && ((is_54_55 && wb == FCAD_D_10 && d3_r == FCAD_D_80) ||
                         (wb == FCAD_D_30 && d3_r == FCAD_D_80) || (is_54_55 && wb == d3_r));
        FCAD_S_ER6: hit = addr_ok && wb == d3_r;
        FCAD_S_IDA: hit = addr_ok && wb == 8'h00;
        FCAD_S_PGM: hit = addr_ok;
        default: hit = 1'b0;
      endcase
      if (!hit) state_nxt = FCAD_S_IDLE;
      else begin
        case (state_r)
          FCAD_S_IDLE: state_nxt = FCAD_S_C1;
          FCAD_S_C1: state_nxt = FCAD_S_C2;
          FCAD_S_C2: begin
            if (wb == FCAD_D_F0) state_nxt = FCAD_S_RDA;
            else if (wb == FCAD_D_90) state_nxt = FCAD_S_IDA;
            else if (wb == FCAD_D_A0) state_nxt = FCAD_S_PGM;
            else state_nxt = FCAD_S_ER3;
          end
          FCAD_S_ER3: state_nxt = FCAD_S_ER4;
          FCAD_S_ER4: state_nxt = FCAD_S_ER5;
          FCAD_S_ER5: state_nxt = (d3_r == FCAD_D_80) ? FCAD_S_IDLE : FCAD_S_ER6;
          FCAD_S_ER6: state_nxt = FCAD_S_IDLE;
          FCAD_S_IDA: state_nxt = FCAD_S_IDRD;
          FCAD_S_PGM: state_nxt = (word_cnt_r == 2'(FCAD_PAGE_WORDS - 1)) ? FCAD_S_IDLE : FCAD_S_PGM;
          default: state_nxt = FCAD_S_IDLE;
        endcase
      end
    end else if (rd && (state_r == FCAD_S_IDRD || state_r == FCAD_S_RDA)) begin
      state_nxt = FCAD_S_IDLE;
    end
  end

  // launch only when ready; locked block refused
  // the launch cycle counts as busy, since ready drops only one edge later
  assign fire = wr && hit && ready_r && !op_r.start;

  always_ff @(posedge clk_sys) begin
    if (!resetn) state_r <= FCAD_S_IDLE;
    else if (wr && (!ready_r || op_r.start)) state_r <= FCAD_S_IDLE;
    else state_r <= state_nxt;
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      d3_r <= 8'h00;
      kind_r <= FCAD_K_BLK;
    end else if (wr && state_r == FCAD_S_C2) begin
      d3_r <= wb;
      kind_r <= (wb == FCAD_D_9A) ? FCAD_K_LPGM : (wb == FCAD_D_6A) ? FCAD_K_LERS : FCAD_K_BLK;
    end
  end

  // page words; page latched from the fourth write
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      word_cnt_r <= 2'd0;
      program_page_selector <= 11'h000;
    end else if (wr && state_r == FCAD_S_PGM && hit) begin
      word_cnt_r <= word_cnt_r + 2'd1;
      if (word_cnt_r == 2'd0) program_page_selector <= a[19:9];
    end else if (state_r != FCAD_S_PGM) begin
      word_cnt_r <= 2'd0;
    end
  end

  // id selector and read answer
  always_ff @(posedge clk_sys) begin
    if (!resetn) id_sel_r <= FCAD_ID_MFR;
    else if (wr && state_r == FCAD_S_IDA && hit) id_sel_r <= a[15:14];
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      rdata_r <= 32'h0000_0000;
      id_mode_r <= 1'b0;
    end else begin
      id_mode_r <= rd && state_r == FCAD_S_IDRD;
      rdata_r <= 32'h0000_0000;
      if (rd && state_r == FCAD_S_IDRD) begin
        if (id_sel_r == FCAD_ID_MFR) rdata_r[7:0] <= MFR_CODE;
        else if (id_sel_r == FCAD_ID_DEV) rdata_r[7:0] <= DEV_CODE;
        else if (id_sel_r == FCAD_ID_MAC) rdata_r[7:0] <= MAC_CODE;
      end
    end
  end

  // array launches
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      op_r <= '0;
    end else begin
      op_r.start <= 1'b0;
      if (fire && state_r == FCAD_S_PGM && !lock_flags_r[blk_of({page_sel, 9'h000})]) begin
        op_r.start <= 1'b1;
        op_r.op <= FCAD_OP_PAGE;
        op_r.page <= page_sel;
        op_r.block <= blk_of(a[19:0]);
        op_r.data <= bus_in.wdata;
      end else if (fire && state_r == FCAD_S_ER5 && d3_r == FCAD_D_80 && wb == FCAD_D_30 &&
                   !lock_flags_r[blk_of(a[19:0])]) begin
        op_r.start <= 1'b1;
        op_r.op <= FCAD_OP_BLK;
        op_r.block <= blk_of(a[19:0]);
      end else if (fire && state_r == FCAD_S_ER5 && d3_r == FCAD_D_80 && wb == FCAD_D_10 &&
                   lock_flags_r == 10'h000) begin
        op_r.start <= 1'b1;
        op_r.op <= FCAD_OP_CHIP;
      end
    end
  end

  // lock bits
  always_ff @(posedge clk_sys) begin
    if (!resetn) lock_flags_r <= FCAD_LOCK_RST;
    else if (fire && state_r == FCAD_S_ER6 && kind_r == FCAD_K_LPGM && a[19] == 1'b0 && a[16:11] == 6'h00) begin
      if (a[18:17] == FCAD_GRP_HI && !a[10]) lock_flags_r[4'd8 + {3'h0, a[9]}] <= 1'b1;
      else if (a[18:17] == FCAD_GRP_MID) lock_flags_r[4'd4 + {2'h0, a[10:9]}] <= 1'b1;
      else if (a[18:17] == FCAD_GRP_LO) lock_flags_r[{2'h0, a[10:9]}] <= 1'b1;
    end else if (fire && state_r == FCAD_S_ER6 && kind_r == FCAD_K_LERS) begin
      lock_flags_r <= lock_flags_r & ~grp_mask(a[18:17]);
    end
  end

  // ready/busy; failure holds busy until reset
  always_ff @(posedge clk_sys) begin
    if (!resetn) ready_r <= FCAD_RDY_RST;
    else if (op_r.start) ready_r <= 1'b0;
    else if (op_done && !op_fail) ready_r <= 1'b1;
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) seq_abort_r <= 1'b0;
    else seq_abort_r <= wr && !hit && state_r != FCAD_S_IDLE;
  end
endmodule

//--- dv/fcad_decoder_chk.sv
// fcad_decoder_chk: port-level checks of the flash command decoder
// assumes one clock domain and bind into fcad_decoder
`timescale 1ns/1ps
module fcad_decoder_chk (
  // clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // core bus
  input fcad_pkg::fcad_bus_type bus_in,
  input wire logic [31:0] rdata_r,
  input wire logic id_mode_r,
  // array engine
  input fcad_pkg::fcad_op_type op_r,
  input wire logic op_done,
  input wire logic op_fail,
  // status
  input wire logic auto_op_ready_flag,
  input wire logic [9:0] lock_flags_r,
  input wire logic seq_abort_r
);
  import fcad_pkg::*;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  sequence s_launch; op_r.start ##1 !op_r.start; endsequence
  sequence s_busy; !auto_op_ready_flag; endsequence
  chk_start_then_busy: assert property (op_r.start |-> s_launch ##0 s_busy) else $error("no busy after start");
  chk_done_ready: assert property (op_done && !op_fail |=> auto_op_ready_flag) else $error("no ready after done");
  chk_fail_holds: assert property (op_done && op_fail |=> s_busy [*3]) else $error("ready after failure");
  chk_id_read_code: assert property (id_mode_r |-> $past(bus_in.valid) && !$past(bus_in.write) && rdata_r[31:8] == 24'h0)
    else $error("bad id answer");
  chk_read_zero: assert property (!id_mode_r |-> rdata_r == 32'h0) else $error("read data not zero");
  chk_abort_quiet: assert property (seq_abort_r |-> $past(bus_in.valid) && !op_r.start) else $error("abort launched");
  chk_lock_block: assert property (op_r.start && op_r.op == FCAD_OP_BLK |-> !lock_flags_r[op_r.block])
    else $error("locked block erased");
  chk_chip_unlock: assert property (op_r.start && op_r.op == FCAD_OP_CHIP |-> lock_flags_r == 10'h000)
    else $error("chip erase with lock");
  chk_page_word: assert property (op_r.start && op_r.op == FCAD_OP_PAGE |->
    op_r.data == $past(bus_in.wdata) && op_r.page == $past(bus_in.addr[19:9])) else $error("bad page word");
endmodule
bind fcad_decoder fcad_decoder_chk chk_u (.clk_sys(clk_sys), .resetn(resetn), .bus_in(bus_in), .rdata_r(rdata_r),
  .id_mode_r(id_mode_r), .op_r(op_r), .op_done(op_done), .op_fail(op_fail),
  .auto_op_ready_flag(auto_op_ready_flag), .lock_flags_r(lock_flags_r), .seq_abort_r(seq_abort_r));

//--- dv/fcad_engine_model.sv
// fcad_engine_model: array engine answering launched operations
// assumes one-cycle start pulses; delay and failure set by the bench
`timescale 1ns/1ps
module fcad_engine_model (
  // clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // launch and control
  input wire logic start,
  input wire logic [3:0] delay,
  input wire logic fail_en,
  // answer
  output logic op_done,
  output logic op_fail
);
  logic [3:0] cnt_r;
  logic run_r;
  always_ff @(posedge clk_sys) begin
    if (!resetn || start) begin
      run_r <= start && resetn;
      cnt_r <= delay;
    end else if (run_r) begin
      cnt_r <= cnt_r - 4'h1;
      run_r <= cnt_r != 4'h0;
    end
  end
  // failure only on request, so a worn array is seen only where a test asks
  assign op_done = run_r && cnt_r == 4'h0;
  assign op_fail = op_done && fail_en;
endmodule

//--- dv/fcad_decoder_tb_top.sv
// fcad_decoder_tb_top: directed bench of command sequences on the decoder bus
// assumes default id codes of the decoder and the engine model on the array side
`timescale 1ns/1ps
module fcad_decoder_tb_top;
  import fcad_pkg::*;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  fcad_bus_type bus_in = '0;
  logic [31:0] rdata_r;
  logic id_mode_r, op_done, op_fail, auto_op_ready_flag, seq_abort_r;
  fcad_op_type op_r;
  logic [9:0] lock_flags_r;
  logic [3:0] delay = 4'h1;
  logic fail_en = 1'b0;
  logic [7:0] idc [4] = '{8'h11, 8'h22, 8'h00, 8'h33};
  logic [31:0] bat [4] = '{32'h000f_fffc, 32'h0001_0000, 32'h0000_7ffc, 32'h0008_0000};
  logic [3:0] blk [4] = '{4'h0, 4'h7, 4'h8, 4'h3};
  int num_errors = 0;
  int compares = 0;
  fcad_decoder dut_u (.clk_sys(clk_sys), .resetn(resetn), .bus_in(bus_in), .rdata_r(rdata_r), .id_mode_r(id_mode_r),
    .op_r(op_r), .op_done(op_done), .op_fail(op_fail), .auto_op_ready_flag(auto_op_ready_flag),
    .lock_flags_r(lock_flags_r), .seq_abort_r(seq_abort_r));
  fcad_engine_model eng_u (.clk_sys(clk_sys), .resetn(resetn), .start(op_r.start), .delay(delay),
    .fail_en(fail_en), .op_done(op_done), .op_fail(op_fail));
  initial begin
    forever #50 clk_sys = ~clk_sys;
  end
  task automatic finish_test;
    if (num_errors == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // upper half keeps the target address, command byte in 15:8
  function automatic logic [31:0] ca(input logic [31:0] a, input logic [7:0] b);
    return {a[31:16], b, 8'h00};
  endfunction
  task automatic acc(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    bus_in <= '{1'b1, w, a, d};
  endtask
  task automatic stop();
    @(posedge clk_sys);
    bus_in <= '0;
    #1;
  endtask
  task automatic wait_ready();
    for (int n = 0; n < 40; n++) begin
      @(posedge clk_sys);
      #1;
      if (auto_op_ready_flag === 1'b1) return;
    end
    num_errors++;
    $display("ERROR %0t got %h exp %h", $time, auto_op_ready_flag, 1'b1);
    finish_test();
  endtask
  task automatic pre(input logic [31:0] a, input logic [7:0] p, input logic [31:0] x, input logic [7:0] c);
    acc(1'b1, ca(a, p), {24'h0, FCAD_D_AA});
    acc(1'b1, ca(a, 8'haa), {24'h0, FCAD_D_55});
    acc(1'b1, x, {24'h0, c});
  endtask
  task automatic erase(input logic [31:0] ba, input logic [7:0] c = FCAD_D_30);
    pre(ba, 8'h54, ca(ba, 8'h54), FCAD_D_80);
    pre(ba, 8'h55, (c == FCAD_D_30) ? ba : ca(ba, 8'h54), c);
    stop();
  endtask
  task automatic lock(input logic [31:0] lock_bit_selector_address, input logic [7:0] c);
    pre(lock_bit_selector_address, 8'h54, ca(lock_bit_selector_address, 8'h54), c);
    pre(lock_bit_selector_address, 8'h54, ca(lock_bit_selector_address, 8'h55), c);
    acc(1'b1, lock_bit_selector_address, {24'h0, c});
    stop();
    wait_ready();
  endtask
  initial begin
    repeat (3) @(posedge clk_sys);
    resetn <= 1'b1;
    #1;
    check(32'({auto_op_ready_flag, lock_flags_r}), 32'h400);
    pre(32'h0, 8'h54, 32'h5400, FCAD_D_F0);
    acc(1'b0, 32'h0, 32'h0);
    stop();
    check(rdata_r, 32'h0);
    check(32'(id_mode_r), 32'h0);
    for (int i = 0; i < 4; i++) begin
      pre(32'h0, i[0] ? 8'h55 : 8'h54, 32'h5400, FCAD_D_90);
      acc(1'b1, {16'h0, i[1:0], 14'h00fc}, 32'h0);
      acc(1'b0, 32'h0, 32'h0);
      stop();
      check(rdata_r, {24'h0, idc[i]});
      check(32'(id_mode_r), 32'h1);
    end
    lock(32'h0004_0200, FCAD_D_9A);
    check(32'(lock_flags_r), 32'h200);
    lock(32'h0002_0000, FCAD_D_9A);
    check(32'(lock_flags_r), 32'h210);
    erase(32'h0000_8000);
    check(32'(op_r.start), 32'h0);
    wait_ready();
    for (int i = 0; i < 4; i++) begin
      delay <= i[0] ? 4'h9 : 4'h1;
      erase(bat[i]);
      check(32'({op_r.start, op_r.op, op_r.block}), 32'({1'b1, FCAD_OP_BLK, blk[i]}));
      wait_ready();
    end
    lock(32'h0002_0000, FCAD_D_6A);
    check(32'(lock_flags_r), 32'h200);
    erase(32'h0, FCAD_D_10);
    check(32'(op_r.start), 32'h0);
    pre(32'h0003_fe00, 8'h54, 32'h0003_5400, FCAD_D_A0);
    for (int j = 0; j < 4; j++) begin
      acc(1'b1, 32'h0003_fe00 + 32'(j * 4), 32'h3c3c_0000 + 32'(j));
      stop();
      check({op_r.start, 9'h0, op_r.page, op_r.data[10:0]}, {1'b1, 9'h0, 11'h1ff, 11'(j)});
      wait_ready();
    end
    acc(1'b1, 32'h5400, 32'haa);
    acc(1'b1, 32'haa00, 32'h12);
    stop();
    check(32'(seq_abort_r), 32'h1);
    fail_en <= 1'b1;
    erase(32'h0004_0000);
    repeat (12) @(posedge clk_sys);
    #1;
    check(32'(auto_op_ready_flag), 32'h0);
    @(posedge clk_sys);
    resetn <= 1'b0;
    fail_en <= 1'b0;
    @(posedge clk_sys);
    resetn <= 1'b1;
    #1;
    check(32'({auto_op_ready_flag, lock_flags_r}), 32'h400);
    erase(32'h0, FCAD_D_10);
    check(32'({op_r.start, op_r.op}), 32'({1'b1, FCAD_OP_CHIP}));
    wait_ready();
    finish_test();
  end
endmodule
